// ==== design/ssc_fw_version.sv ====
// Firmware version window: selector write picks which 16-bit version shows in two bytes
`default_nettype none
module ssc_fw_version #(
	parameter logic [15:0] MAJOR_VER = 16'h0001,  // Major version
	parameter logic [15:0] PATCH_VER = 16'h0000,  // Patch version
	parameter logic [15:0] BUILD_VER = 16'h0001   // Build version
) (
	input  wire logic       core_clk,  // System clock
	input  wire logic       rst_n,     // Async reset, active low
	input  wire logic       clr,       // Soft reset clear
	input  wire logic       sel_wr,    // Selector write strobe
	input  wire logic [7:0] sel_data,  // Selector value
	output logic      [7:0] upper_q,   // High byte of selected version
	output logic      [7:0] lower_q    // Low byte of selected version
);
	////////////////////////////////////////////////////////////////////////
	// Selector decode; any other code blanks both bytes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_q <= ssc_pkg::FW_BYTE_RST;
			lower_q <= ssc_pkg::FW_BYTE_RST;
		end else if (clr) begin
			upper_q <= ssc_pkg::FW_BYTE_RST;
			lower_q <= ssc_pkg::FW_BYTE_RST;
		end else if (sel_wr) begin
			case (sel_data)
				ssc_pkg::FW_SEL_MAJOR: begin
					upper_q <= MAJOR_VER[15:8];
					lower_q <= MAJOR_VER[7:0];
				end
				ssc_pkg::FW_SEL_PATCH: begin
					upper_q <= PATCH_VER[15:8];
					lower_q <= PATCH_VER[7:0];
				end
				ssc_pkg::FW_SEL_BUILD: begin
					upper_q <= BUILD_VER[15:8];
					lower_q <= BUILD_VER[7:0];
				end
				default: begin
					upper_q <= ssc_pkg::FW_BYTE_RST;
					lower_q <= ssc_pkg::FW_BYTE_RST;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== design/ssc_int_timer.sv ====
// Integration timer: step divider and step counter that signal end of each integration
`default_nettype none
module ssc_int_timer #(
	parameter int STEP_CYCLES = ssc_pkg::STEP_CYCLES  // Clock cycles per step
) (
	input  wire logic core_clk,  // System clock
	input  wire logic rst_n,     // Async reset, active low
	ssc_tmr_if.tmr    tif        // Period, restart and done
);
	localparam int CW = $clog2(STEP_CYCLES + 1);

	logic [CW-1:0] div_q;
	logic          step_q;
	logic [7:0]    steps_q;
	logic          done_q;

	////////////////////////////////////////////////////////////////////////
	// Step divider: one-cycle enable at each step boundary
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= '0;
			step_q <= 1'b0;
		end else if (tif.restart || tif.period == 8'h00) begin
			div_q  <= '0;
			step_q <= 1'b0;
		end else if (div_q == CW'(STEP_CYCLES - 1)) begin
			div_q  <= '0;
			step_q <= 1'b1;
		end else begin
			div_q  <= div_q + 1'b1;
			step_q <= 1'b0;
		end
	end

	// Step counter: period steps make one integration; zero period stays idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			steps_q <= 8'h00;
			done_q  <= 1'b0;
		end else if (tif.restart || tif.period == 8'h00) begin
			steps_q <= 8'h00;
			done_q  <= 1'b0;
		end else if (step_q && steps_q + 8'h01 >= tif.period) begin
			steps_q <= 8'h00;
			done_q  <= 1'b1;
		end else begin
			steps_q <= step_q ? steps_q + 8'h01 : steps_q;
			done_q  <= 1'b0;
		end
	end

	assign tif.done = done_q;
endmodule
`default_nettype wire

// ==== design/ssc_pkg.sv ====
// Package: register map, field layout, reset values and timing of the sensor register bank
`default_nettype none
package ssc_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_DEV_TYPE   = 8'h00;
	localparam logic [7:0] IDX_HW_REV     = 8'h01;
	localparam logic [7:0] IDX_FW_UPPER   = 8'h02;
	localparam logic [7:0] IDX_FW_LOWER   = 8'h03;
	localparam logic [7:0] IDX_SETUP      = 8'h04;
	localparam logic [7:0] IDX_PERIOD     = 8'h05;
	localparam logic [7:0] IDX_DIE_TEMP   = 8'h06;
	localparam logic [7:0] IDX_LED_CTRL   = 8'h07;
	localparam logic [7:0] IDX_EXT_PRES   = 8'h4F;
	localparam logic [7:0] IDX_INT_STATUS = 8'h80;
	localparam logic [7:0] IDX_INT_MASK   = 8'h81;

	// Field positions of the sensor_setup byte
	localparam int SETUP_SWRST_BIT = 7;
	localparam int SETUP_GAIN_LSB  = 4;
	localparam int SETUP_RDY_BIT   = 1;
	localparam int SETUP_SOFT_BIT  = 0;
	// Presence flag position and LED enable position
	localparam int EXT_PRES_BIT    = 6;
	localparam int LED_EN_BIT      = 0;
	// Interrupt status bit positions
	localparam int INT_CONV_BIT    = 0;
	localparam int INT_RST_BIT     = 1;
	localparam int INT_W           = 2;

	// Reset values
	localparam logic [1:0] GAIN_RST    = 2'h0;
	localparam logic [7:0] PERIOD_RST  = 8'h14;
	localparam logic       LED_RST     = 1'b1;
	localparam logic [7:0] FW_BYTE_RST = 8'h00;

	// Firmware version selector codes
	localparam logic [7:0] FW_SEL_MAJOR = 8'h01;
	localparam logic [7:0] FW_SEL_PATCH = 8'h02;
	localparam logic [7:0] FW_SEL_BUILD = 8'h03;

	// Timing: one integration step and the soft reset sequence length
	localparam int  CLK_FREQ_KHZ      = 40000;
	localparam real STEP_TIME_MS      = 2.8;
	localparam int  STEP_CYCLES       = int'(STEP_TIME_MS * CLK_FREQ_KHZ);
	localparam int  SOFT_RESET_CYCLES = 8;

	// Soft reset sequencer states, Gray coded
	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_BUSY = 2'b01,
		SR_DONE = 2'b11
	} ssc_sr_e;
endpackage
`default_nettype wire

// ==== design/ssc_regs.sv ====
// Top: AHB-Lite register bank of the colour sensor with config, timer, version and interrupts
//
// Summary of operation
// - Writing 1, 2 or 3 to either version byte selects the shown version.
// - Any other value written to a version byte blanks both bytes to zero.
// - Selector 1 shows major, 2 patch, 3 build; each sixteen bits wide.
// - High byte at the lower address, low byte next; both read-only.
// - Setup bit 7 reads gain error; writing one starts a software reset.
// - Gain field bits 5:4 select 1x, 3.7x, 16x or 64x; resets to 00.
// - Data-ready bit sets on conversion end; clears when read while set, or reset.
// - Writing one to bit 0 starts soft reset; reads zero once finished.
// - Integration lasts stored value times 2.8 ms; values 1 to 255 valid.
// - Temperature byte is read-only die temperature, unsigned degrees Celsius.
// - Presence byte bit 6 reads one when external light sensor present.
//
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none
module ssc_regs #(
	parameter int          ADDR_W     = 10,                    // Decoded address bits
	parameter int          STEP_CYCLES = ssc_pkg::STEP_CYCLES, // Cycles per 2.8 ms step
	parameter logic [7:0]  DEV_TYPE   = 8'h5A,                 // Arbitrary identity value
	parameter logic [7:0]  HW_REV     = 8'h02,                 // Arbitrary identity value
	parameter logic [15:0] MAJOR_VER  = 16'h0001,              // Firmware major
	parameter logic [15:0] PATCH_VER  = 16'h0000,              // Firmware patch
	parameter logic [15:0] BUILD_VER  = 16'h0001               // Firmware build
) (
	input  wire logic        core_clk,                 // 40 MHz system clock
	input  wire logic        rst_n,                    // Async reset, active low
	input  wire logic        hsel,                     // AHB slave select
	input  wire logic [31:0] haddr,                    // AHB address
	input  wire logic [1:0]  htrans,                   // AHB transfer type
	input  wire logic        hwrite,                   // AHB write
	input  wire logic [2:0]  hsize,                    // AHB size, word only
	input  wire logic [31:0] hwdata,                   // AHB write data
	input  wire logic        hready,                   // AHB bus ready
	output logic      [31:0] hrdata,                   // AHB read data
	output logic             hreadyout,                // AHB slave ready
	output logic             hresp,                    // AHB response, always OKAY
	input  wire logic [7:0]  die_temp,                 // Die temperature, deg C
	input  wire logic        external_light_sensor_present, // External sensor found
	input  wire logic        sensor_gain_error,        // Gain error from sensor
	output logic      [1:0]  gain_select,              // Sensor gain code
	output logic             indicator_led_output,     // Indicator LED enable
	output logic             irq                       // Level interrupt
);
	ssc_tmr_if tif ();

	logic [31:0]         hrdata_q;
	logic                hreadyout_q;
	logic                hresp_q;
	logic                wr_pend_q;
	logic [ADDR_W-3:0]   wr_idx_q;
	logic                irq_q;
	logic [1:0]          gain_q;
	logic [7:0]          period_q;
	logic                led_q;
	logic                rdy_q;
	logic [ssc_pkg::INT_W-1:0] int_sta_q;
	logic [ssc_pkg::INT_W-1:0] int_msk_q;
	ssc_pkg::ssc_sr_e    sr_state_q;
	logic [$clog2(ssc_pkg::SOFT_RESET_CYCLES+1)-1:0] sr_cnt_q;
	logic [7:0]          fw_upper;
	logic [7:0]          fw_lower;

	logic                addr_ok;
	logic                rd_take;
	logic                wr_take;
	logic [ADDR_W-3:0]   rd_idx;
	logic [7:0]          wbyte;
	logic                wr_setup;
	logic                wr_fw;
	logic                sr_start;
	logic                sr_clr;
	logic                rdy_read;
	logic [7:0]          rd_byte;

	////////////////////////////////////////////////////////////////////////
	// Bus decode: word-aligned single transfers in the decoded range
	assign addr_ok  = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);
	assign rd_take  = hsel && hready && htrans[1] && !hwrite;
	assign wr_take  = hsel && hready && htrans[1] && hwrite && addr_ok;
	assign rd_idx   = addr_ok ? haddr[ADDR_W-1:2] : '1;
	assign wbyte    = hwdata[7:0];
	assign wr_setup = wr_pend_q && wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_SETUP);
	assign wr_fw    = wr_pend_q && (wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_FW_UPPER) ||
		wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_FW_LOWER));

	// Either reset request bit starts the soft reset sequence
	assign sr_start = wr_setup && sr_state_q == ssc_pkg::SR_IDLE &&
		(wbyte[ssc_pkg::SETUP_SWRST_BIT] || wbyte[ssc_pkg::SETUP_SOFT_BIT]);
	assign sr_clr   = sr_start;
	assign rdy_read = rd_take && rd_idx == (ADDR_W-2)'(ssc_pkg::IDX_SETUP) && rdy_q;

	////////////////////////////////////////////////////////////////////////
	// Address phase capture: writes complete one cycle later in the data phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
		end else begin
			wr_pend_q <= wr_take;
			wr_idx_q  <= haddr[ADDR_W-1:2];
		end
	end

	// Zero wait state slave, always OKAY
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux: reserved bits and unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		case (rd_idx)
			(ADDR_W-2)'(ssc_pkg::IDX_DEV_TYPE): rd_byte = DEV_TYPE;
			(ADDR_W-2)'(ssc_pkg::IDX_HW_REV):   rd_byte = HW_REV;
			(ADDR_W-2)'(ssc_pkg::IDX_FW_UPPER): rd_byte = fw_upper;
			(ADDR_W-2)'(ssc_pkg::IDX_FW_LOWER): rd_byte = fw_lower;
			(ADDR_W-2)'(ssc_pkg::IDX_SETUP): begin
				rd_byte[ssc_pkg::SETUP_SWRST_BIT] = sensor_gain_error;
				rd_byte[ssc_pkg::SETUP_GAIN_LSB +: 2] = gain_q;
				rd_byte[ssc_pkg::SETUP_RDY_BIT] = rdy_q;
				rd_byte[ssc_pkg::SETUP_SOFT_BIT] = (sr_state_q != ssc_pkg::SR_IDLE);
			end
			(ADDR_W-2)'(ssc_pkg::IDX_PERIOD):   rd_byte = period_q;
			(ADDR_W-2)'(ssc_pkg::IDX_DIE_TEMP): rd_byte = die_temp;
			(ADDR_W-2)'(ssc_pkg::IDX_LED_CTRL): rd_byte[ssc_pkg::LED_EN_BIT] = led_q;
			(ADDR_W-2)'(ssc_pkg::IDX_EXT_PRES):
				rd_byte[ssc_pkg::EXT_PRES_BIT] = external_light_sensor_present;
			(ADDR_W-2)'(ssc_pkg::IDX_INT_STATUS):
				rd_byte[ssc_pkg::INT_W-1:0] = int_sta_q;
			(ADDR_W-2)'(ssc_pkg::IDX_INT_MASK):
				rd_byte[ssc_pkg::INT_W-1:0] = int_msk_q;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data registered at the address phase edge, shown in the data phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata_q <= {24'h00_0000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gain field; reserved bits of the write are dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_q <= ssc_pkg::GAIN_RST;
		end else if (sr_clr) begin
			gain_q <= ssc_pkg::GAIN_RST;
		end else if (wr_setup) begin
			gain_q <= wbyte[ssc_pkg::SETUP_GAIN_LSB +: 2];
		end
	end

	// Integration period; only written at its own address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			period_q <= ssc_pkg::PERIOD_RST;
		end else if (sr_clr) begin
			period_q <= ssc_pkg::PERIOD_RST;
		end else if (wr_pend_q && wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_PERIOD)) begin
			period_q <= wbyte;
		end
	end

	// Indicator LED enable
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_q <= ssc_pkg::LED_RST;
		end else if (sr_clr) begin
			led_q <= ssc_pkg::LED_RST;
		end else if (wr_pend_q && wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_LED_CTRL)) begin
			led_q <= wbyte[ssc_pkg::LED_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data ready: set by conversion end, which wins over a clearing read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_q <= 1'b0;
		end else if (tif.done) begin
			rdy_q <= 1'b1;
		end else if (sr_clr || rdy_read) begin
			rdy_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Soft reset sequencer: busy for a fixed count, then reports done
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_state_q <= ssc_pkg::SR_IDLE;
			sr_cnt_q   <= '0;
		end else begin
			case (sr_state_q)
				ssc_pkg::SR_IDLE: begin
					if (sr_start) begin
						sr_state_q <= ssc_pkg::SR_BUSY;
						sr_cnt_q   <= '0;
					end
				end
				ssc_pkg::SR_BUSY: begin
					if (sr_cnt_q == ($bits(sr_cnt_q))'(ssc_pkg::SOFT_RESET_CYCLES - 1)) begin
						sr_state_q <= ssc_pkg::SR_DONE;
					end else begin
						sr_cnt_q <= sr_cnt_q + 1'b1;
					end
				end
				ssc_pkg::SR_DONE: begin
					sr_state_q <= ssc_pkg::SR_IDLE;
				end
				default: begin
					sr_state_q <= ssc_pkg::SR_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: events set, write one clears, set wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_sta_q <= '0;
		end else begin
			for (int i = 0; i < ssc_pkg::INT_W; i++) begin
				if ((i == ssc_pkg::INT_CONV_BIT && tif.done) ||
					(i == ssc_pkg::INT_RST_BIT && sr_state_q == ssc_pkg::SR_DONE)) begin
					int_sta_q[i] <= 1'b1;
				end else if (wr_pend_q && wbyte[i] &&
					wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_INT_STATUS)) begin
					int_sta_q[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt mask and registered level output
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_msk_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			if (wr_pend_q && wr_idx_q == (ADDR_W-2)'(ssc_pkg::IDX_INT_MASK)) begin
				int_msk_q <= wbyte[ssc_pkg::INT_W-1:0];
			end
			irq_q <= |(int_sta_q & int_msk_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer runs from the stored period; held during soft reset
	assign tif.period  = period_q;
	assign tif.restart = (sr_state_q != ssc_pkg::SR_IDLE);

	ssc_int_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tif      (tif.tmr)
	);

	// Firmware version window
	ssc_fw_version #(
		.MAJOR_VER (MAJOR_VER),
		.PATCH_VER (PATCH_VER),
		.BUILD_VER (BUILD_VER)
	) u_fw (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clr      (sr_clr),
		.sel_wr   (wr_fw),
		.sel_data (wbyte),
		.upper_q  (fw_upper),
		.lower_q  (fw_lower)
	);

	// Identity, temperature and presence bytes have no write path
	assign hrdata               = hrdata_q;
	assign hreadyout            = hreadyout_q;
	assign hresp                = hresp_q;
	assign gain_select          = gain_q;
	assign indicator_led_output = led_q;
	assign irq                  = irq_q;
endmodule
`default_nettype wire

// ==== design/ssc_tmr_if.sv ====
// Interface: control and completion between the register bank and the integration timer
`default_nettype none
interface ssc_tmr_if;
	logic [7:0] period;   // Integration steps
	logic       restart;  // Hold timer at start
	logic       done;     // One-cycle end of integration

	modport ctl (output period, output restart, input done);
	modport tmr (input period, input restart, output done);
endinterface
`default_nettype wire

// ==== test/ssc_host.sv ====
// Host model: AHB-Lite master issuing single word transfers
`default_nettype none
module ssc_host (
	input  wire logic        core_clk, // Clock
	output logic             hsel,     // Select
	output logic      [31:0] haddr,    // Address
	output logic      [1:0]  htrans,   // Transfer type
	output logic             hwrite,   // Write
	output logic      [2:0]  hsize,    // Size, word
	output logic      [31:0] hwdata,   // Write data
	input  wire logic        hready,   // Bus ready
	input  wire logic [31:0] hrdata    // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Address phase held until ready, then data phase held until ready
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		r = hrdata;
		haddr <= ~a;  // Released lines carry no stale value
		hwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== test/ssc_regs_checker.sv ====
// Checker: bus answers, read-back and write effects of the sensor register bank
`default_nettype none
module ssc_regs_checker #(
	parameter logic [7:0] DEV_TYPE = 8'h00, // Identity value
	parameter logic [7:0] HW_REV   = 8'h00  // Identity value
) (
	input wire logic        core_clk,                      // Clock
	input wire logic        rst_n,                         // Reset, active low
	input wire logic        hsel,                          // Select
	input wire logic [31:0] haddr,                         // Address
	input wire logic [1:0]  htrans,                        // Transfer type
	input wire logic        hwrite,                        // Write
	input wire logic [31:0] hwdata,                        // Write data
	input wire logic        hready,                        // Bus ready
	input wire logic [31:0] hrdata,                        // Read data
	input wire logic        hreadyout,                     // Slave ready
	input wire logic        hresp,                         // Response
	input wire logic [7:0]  die_temp,                      // Temperature
	input wire logic        external_light_sensor_present, // Presence
	input wire logic        sensor_gain_error,             // Gain error
	input wire logic [1:0]  gain_select,                   // Gain code
	input wire logic        indicator_led_output           // LED enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       tk;
	logic       rd_t;
	logic [7:0] idx;
	logic       wr_q;
	logic [7:0] widx_q;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Transfer taken and its register index
	assign tk = hsel & hready & htrans[1];
	assign idx = haddr[9:2];
	assign rd_t = tk & !hwrite & (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h0);
	// Marks the data phase of a mapped write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			widx_q <= 8'h00;
		end else begin
			wr_q <= tk & hwrite & (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h0);
			widx_q <= idx;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_bus: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	a_temp: assert property (rd_t && idx == ssc_pkg::IDX_DIE_TEMP |=>
		hrdata == {24'h0, $past(die_temp)})
		else $error("temperature read wrong");
	a_pres: assert property (rd_t && idx == ssc_pkg::IDX_EXT_PRES |=>
		hrdata == {25'h0, $past(external_light_sensor_present), 6'h0})
		else $error("presence read wrong");
	a_ident: assert property (rd_t && idx == ssc_pkg::IDX_DEV_TYPE |=>
		hrdata == {24'h0, DEV_TYPE})
		else $error("device type read wrong");
	a_rev: assert property (rd_t && idx == ssc_pkg::IDX_HW_REV |=>
		hrdata == {24'h0, HW_REV})
		else $error("revision read wrong");
	a_setup: assert property (rd_t && idx == ssc_pkg::IDX_SETUP |=>
		hrdata[7:2] == {$past(sensor_gain_error), 1'b0, $past(gain_select), 2'b00})
		else $error("setup read wrong");
	a_gain: assert property (wr_q && widx_q == ssc_pkg::IDX_SETUP && !hwdata[7] && !hwdata[0]
		|=> gain_select == $past(hwdata[5:4]))
		else $error("gain not taken from write");
	a_led: assert property (wr_q && widx_q == ssc_pkg::IDX_LED_CTRL
		|=> indicator_led_output == $past(hwdata[0]))
		else $error("led enable not taken from write");
	a_soft: assert property (wr_q && widx_q == ssc_pkg::IDX_SETUP && hwdata[0]
		|-> ##[1:11] (gain_select == 2'h0 && indicator_led_output))
		else $error("soft reset did not restore gain and led");
	a_unmap: assert property (tk && !hwrite && haddr[1:0] != 2'h0 |=> hrdata == 32'h0)
		else $error("misaligned read not zero");
endmodule
bind ssc_regs ssc_regs_checker #(.DEV_TYPE(DEV_TYPE), .HW_REV(HW_REV)) u_chk (
	.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .die_temp, .external_light_sensor_present, .sensor_gain_error,
	.gain_select, .indicator_led_output);
`default_nettype wire

// ==== test/ssc_regs_tb.sv ====
// Testbench: register bank driven through host bus transfers against expected values
`default_nettype none
`define CHK(act, exp) begin \
	samples_checked++; \
	if ((act) !== (exp)) begin \
		bad_count++; \
		$display("mismatch at %0t: got %0h expected %0h", $time, (act), (exp)); \
	end \
end
module ssc_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          STEP = 10;       // Shortened integration step
	localparam logic [7:0]  DEVT = 8'h3C;    // Arbitrary identity value
	localparam logic [7:0]  HREV = 8'h07;    // Arbitrary identity value
	localparam logic [15:0] VMAJ = 16'h1234; // Version values
	localparam logic [15:0] VPAT = 16'h5678;
	localparam logic [15:0] VBLD = 16'h9ABC;
	logic        core_clk, rst_n, hsel, hwrite, hrdy, irq, led, pres, gerr;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans, gain;
	logic [2:0]  hsize;
	logic [7:0]  temp;
	logic [15:0] v;
	logic [7:0]  code [2] = '{8'h31, 8'hB0};
	int          bad_count = 0, samples_checked = 0, cyc = 0, t0, t1;
	ssc_regs #(.STEP_CYCLES(STEP), .DEV_TYPE(DEVT), .HW_REV(HREV), .MAJOR_VER(VMAJ),
		.PATCH_VER(VPAT), .BUILD_VER(VBLD)) DUT (
		.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy),
		.hrdata, .hreadyout(hrdy), .hresp(), .die_temp(temp),
		.external_light_sensor_present(pres), .sensor_gain_error(gerr), .gain_select(gain),
		.indicator_led_output(led), .irq);
	ssc_host host (.core_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hrdy), .hrdata);
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] x;
		host.xfer({22'h0, i, 2'h0}, 1'b1, {24'h0, d}, x);
	endtask
	// Read one register and compare the masked value
	task automatic ck(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m = '1);
		logic [31:0] x;
		host.xfer({22'h0, i, 2'h0}, 1'b0, 32'h0, x);
		`CHK(x & m, e)
	endtask
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		t = cyc;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		temp = 8'h2B;
		pres = 1'b1;
		gerr = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values, then writes to read-only bytes
		ck(ssc_pkg::IDX_PERIOD, 32'h14);
		ck(ssc_pkg::IDX_LED_CTRL, 32'h1);
		ck(ssc_pkg::IDX_SETUP, 32'h0, 32'hFFFFFFFD);
		wr(ssc_pkg::IDX_DEV_TYPE, 8'hFF);
		wr(ssc_pkg::IDX_HW_REV, 8'h00);
		wr(ssc_pkg::IDX_DIE_TEMP, 8'h00);
		wr(ssc_pkg::IDX_EXT_PRES, 8'h00);
		ck(ssc_pkg::IDX_DEV_TYPE, {24'h0, DEVT});
		ck(ssc_pkg::IDX_HW_REV, {24'h0, HREV});
		ck(ssc_pkg::IDX_DIE_TEMP, 32'h2B);
		ck(ssc_pkg::IDX_EXT_PRES, 32'h40);
		temp <= 8'h91;
		pres <= 1'b0;
		ck(ssc_pkg::IDX_DIE_TEMP, 32'h91);
		ck(ssc_pkg::IDX_EXT_PRES, 32'h00);
		// Version window: selectors 1 to 3, then a value out of range
		ck(ssc_pkg::IDX_FW_UPPER, 32'h0);
		for (int s = 1; s <= 4; s++) begin
			wr(s[0] ? ssc_pkg::IDX_FW_UPPER : ssc_pkg::IDX_FW_LOWER, s[7:0]);
			v = (s == 1) ? VMAJ : (s == 2) ? VPAT : (s == 3) ? VBLD : 16'h0;
			ck(ssc_pkg::IDX_FW_UPPER, {24'h0, v[15:8]});
			ck(ssc_pkg::IDX_FW_LOWER, {24'h0, v[7:0]});
		end
		// Every gain code, with the error flag raised
		gerr <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			wr(ssc_pkg::IDX_SETUP, {2'b00, g[1:0], 4'h0});
			@(negedge core_clk);
			`CHK(gain, g[1:0])
			ck(ssc_pkg::IDX_SETUP, {24'h0, 2'b10, g[1:0], 4'h0}, 32'hFFFFFFFD);
		end
		gerr <= 1'b0;
		wr(ssc_pkg::IDX_LED_CTRL, 8'h00);
		@(negedge core_clk);
		`CHK(led, 1'b0)
		ck(ssc_pkg::IDX_LED_CTRL, 32'h0);
		// Period boundary, then data ready clears when read
		wr(ssc_pkg::IDX_PERIOD, 8'hFF);
		ck(ssc_pkg::IDX_PERIOD, 32'hFF);
		// Long period leaves no conversion end near: a read drops a stale ready flag
		host.xfer({22'h0, ssc_pkg::IDX_SETUP, 2'h0}, 1'b0, 32'h0, r);
		ck(ssc_pkg::IDX_SETUP, 32'h0, 32'h2);
		wr(ssc_pkg::IDX_INT_MASK, 8'h00);
		wr(ssc_pkg::IDX_PERIOD, 8'h03);
		r = 32'h0;
		for (int n = 0; n < 40 && r[1] !== 1'b1; n++)
			host.xfer({22'h0, ssc_pkg::IDX_SETUP, 2'h0}, 1'b0, 32'h0, r);
		`CHK(r[1], 1'b1)
		ck(ssc_pkg::IDX_SETUP, 32'h0, 32'h2);
		`CHK(irq, 1'b0)
		// Conversion spacing seen on the interrupt
		wr(ssc_pkg::IDX_INT_MASK, 8'h01);
		wr(ssc_pkg::IDX_INT_STATUS, 8'h03);
		repeat (2) @(posedge core_clk);
		wait_irq(t0);
		wr(ssc_pkg::IDX_INT_STATUS, 8'h01);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b0)
		wait_irq(t1);
		`CHK((t1 - t0 >= 3 * STEP) && (t1 - t0 <= 3 * STEP + 2), 1'b1)
		// Soft reset from bit 0 and from bit 7
		foreach (code[k]) begin
			wr(ssc_pkg::IDX_SETUP, 8'h30);
			wr(ssc_pkg::IDX_LED_CTRL, 8'h00);
			wr(ssc_pkg::IDX_PERIOD, 8'h07);
			wr(ssc_pkg::IDX_FW_UPPER, 8'h01);
			wr(ssc_pkg::IDX_INT_STATUS, 8'h02);
			wr(ssc_pkg::IDX_SETUP, code[k]);
			ck(ssc_pkg::IDX_SETUP, 32'h1, 32'h1);
			repeat (12) @(posedge core_clk);
			ck(ssc_pkg::IDX_SETUP, 32'h0, 32'h33);
			ck(ssc_pkg::IDX_PERIOD, 32'h14);
			ck(ssc_pkg::IDX_LED_CTRL, 32'h1);
			ck(ssc_pkg::IDX_FW_UPPER, 32'h0);
			ck(ssc_pkg::IDX_INT_STATUS, 32'h2, 32'h2);
		end
		// Unmapped and misaligned places
		host.xfer(32'h0000_0414, 1'b1, 32'h55, r);
		ck(ssc_pkg::IDX_PERIOD, 32'h14);
		host.xfer(32'h0000_0400, 1'b0, 32'h0, r);
		`CHK(r, 32'h0)
		host.xfer(32'h0000_0011, 1'b0, 32'h0, r);
		`CHK(r, 32'h0)
		finish_test();
	end
endmodule
`default_nettype wire
